/* File: hw/mcu_decoder_regs.vh */
// Constants shared by the instruction decoder, its arithmetic unit and its cycle timer
`ifndef MCU_DECODER_REGS_VH
`define MCU_DECODER_REGS_VH

// ==========================================================
// Instruction cycle length option
`define CYC_OPT_4CLK 2'b00
`define CYC_OPT_2CLK 2'b01
`define CYC_OPT_8CLK 2'b10
`define CYC_OPT_16CLK 2'b11

// ==========================================================
// Special register selectors
`define PC_REG_ADDR 6'h02

// ==========================================================
// Control opcodes, low six bits with upper field zero
`define OP_NOP 6'h00
`define OP_DAA 6'h01
`define OP_CTRLW 6'h02
`define OP_SLEEP 6'h03
`define OP_WATCHDOG_CLEAR_OP 6'h04
`define OP_ENI 6'h10
`define OP_IRQ_DISABLE_OP 6'h11
`define OP_RET 6'h12
`define OP_IRQ_RETURN_OP 6'h13
`define OP_CTRLR 6'h14

// ==========================================================
// Field positions and literal-group opcodes
`define F_TOP 12
`define F_DEST 6
`define LIT_RETURN_LITERAL_OP 4'hc
`define LIT_TABLE_READ_OP 6'h3b

// ==========================================================
// Arithmetic unit operations
`define ALU_PASS 5'h00
`define ALU_ZERO 5'h01
`define ALU_SUB 5'h02
`define ALU_DEC 5'h03
`define ALU_OR 5'h04
`define ALU_AND 5'h05
`define ALU_XOR 5'h06
`define ALU_ADD 5'h07
`define ALU_COM 5'h08
`define ALU_INC 5'h09
`define ALU_RRC 5'h0a
`define ALU_RLC 5'h0b
`define ALU_SWAP 5'h0c
`define ALU_DAA 5'h0d
`define ALU_PASSA 5'h0e
`define ALU_BCLR 5'h0f
`define ALU_BSET 5'h10

// ==========================================================
// Reset values
`define RST_ACC 8'h00
`define RST_TIMEOUT 1'b1
`define RST_POWERDOWN 1'b1
`define RST_IRQ_EN 1'b0

`endif

/* File: hw/mcu_cycle_timer.v */
// Instruction cycle timer producing one end-of-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
`include "mcu_decoder_regs.vh"

module mcu_cycle_timer (
   input wire i_clk_sys,
   input wire i_rst_b,
   input wire [1:0] i_cycle_length_option,
   output wire o_cycle_end
);

   // ==========================================================
   // Last count of one instruction cycle
   function [3:0] last_count;
      input [1:0] opt;
      begin
         case (opt)
            `CYC_OPT_2CLK: last_count = 4'h1;
            `CYC_OPT_4CLK: last_count = 4'h3;
            `CYC_OPT_8CLK: last_count = 4'h7;
            default: last_count = 4'hf;
         endcase
      end
   endfunction

   reg [3:0] cnt_r;
   wire [3:0] cnt_nxt;

   assign o_cycle_end = (cnt_r >= last_count(i_cycle_length_option));
   assign cnt_nxt = o_cycle_end ? 4'h0 : cnt_r + 4'h1;

   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule
`default_nettype wire

/* File: hw/mcu_alu.v */
// Eight-bit arithmetic and logic unit with carry and digit carry
`timescale 1ns/1ps
`default_nettype none
`include "mcu_decoder_regs.vh"

module mcu_alu (
   input wire [4:0] i_op,
   input wire [7:0] i_a,
   input wire [7:0] i_r,
   input wire [2:0] i_bit,
   input wire i_c,
   input wire i_dc,
   output reg [7:0] o_y,
   output reg o_c,
   output reg o_dc
);

   reg [8:0] s;
   reg [4:0] n;

   always @* begin
      s = 9'h000;
      n = 5'h00;
      o_y = i_r;
      o_c = i_c;
      o_dc = i_dc;
      case (i_op)
         `ALU_PASS: o_y = i_r;
         `ALU_ZERO: o_y = 8'h00;
         `ALU_SUB: begin
            s = {1'b0, i_r} - {1'b0, i_a};
            n = {1'b0, i_r[3:0]} - {1'b0, i_a[3:0]};
            o_y = s[7:0];
            o_c = ~s[8];
            o_dc = ~n[4];
         end
         `ALU_DEC: o_y = i_r - 8'h01;
         `ALU_OR: o_y = i_a | i_r;
         `ALU_AND: o_y = i_a & i_r;
         `ALU_XOR: o_y = i_a ^ i_r;
         `ALU_ADD: begin
            s = {1'b0, i_a} + {1'b0, i_r};
            n = {1'b0, i_a[3:0]} + {1'b0, i_r[3:0]};
            o_y = s[7:0];
            o_c = s[8];
            o_dc = n[4];
         end
         `ALU_COM: o_y = ~i_r;
         `ALU_INC: o_y = i_r + 8'h01;
         `ALU_RRC: begin
            o_y = {i_c, i_r[7:1]};
            o_c = i_r[0];
         end
         `ALU_RLC: begin
            o_y = {i_r[6:0], i_c};
            o_c = i_r[7];
         end
         `ALU_SWAP: o_y = {i_r[3:0], i_r[7:4]};
         `ALU_DAA: begin
            s = {1'b0, i_a};
            if (i_dc || (i_a[3:0] > 4'h9)) begin
               s = s + 9'h006;
            end
            if (i_c || s[8] || (s[7:4] > 4'h9)) begin
               s = s + 9'h060;
               o_c = 1'b1;
            end
            o_y = s[7:0];
         end
         `ALU_PASSA: o_y = i_a;
         `ALU_BCLR: o_y = i_r & ~(8'h01 << i_bit);
         `ALU_BSET: o_y = i_r | (8'h01 << i_bit);
         default: o_y = i_r;
      endcase
   end

endmodule
`default_nettype wire

/* File: hw/mcu_instruction_decoder.v */
// Instruction decoder and sequencer of the eight-bit core
`timescale 1ns/1ps
`default_nettype none
`include "mcu_decoder_regs.vh"

module mcu_instruction_decoder (
   input wire i_clk_sys,
   input wire i_rst_b,
   input wire [1:0] i_cycle_length_option,
   input wire i_instr_valid,
   input wire [12:0] i_instr,
   output wire o_fetch_ready,
   input wire [7:0] i_reg_rdata,
   output reg [5:0] o_reg_addr_r,
   output reg o_reg_we_r,
   output reg [7:0] o_reg_wdata_r,
   input wire [7:0] i_ctrl_rdata,
   output reg o_ctrl_we_r,
   output reg [7:0] o_ctrl_wdata_r,
   input wire [7:0] i_ioc_rdata,
   output reg [3:0] o_ioc_addr_r,
   output reg o_ioc_we_r,
   output reg [7:0] o_ioc_wdata_r,
   input wire [7:0] i_table_data,
   output reg o_table_req_r,
   output reg o_stack_pop_r,
   output reg o_skip_r,
   output reg o_flush_r,
   output reg o_done_r,
   output reg o_wdt_clear_r,
   output reg o_sleep_r,
   output reg o_timeout_flag_r,
   output reg o_powerdown_flag_r,
   output reg o_irq_enable_r,
   output reg [7:0] o_acc_r,
   output reg o_zero_flag_r,
   output reg o_carry_flag_r,
   output reg o_digit_carry_flag_r
);

   // ==========================================================
   // States
   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_EXEC = 3'b010;
   localparam [2:0] S_WAIT = 3'b100;

   // ==========================================================
   // I/O control selector check
   function io_sel_ok;
      input [3:0] sel;
      begin
         io_sel_ok = ((sel >= 4'h5) && (sel <= 4'h7)) || (sel >= 4'ha);
      end
   endfunction

   reg [2:0] st_r;
   reg [2:0] st_nxt;
   reg [12:0] instr_r;
   reg table_read_op_r;

   wire cycle_end;
   wire [7:0] alu_y;
   wire alu_c;
   wire alu_dc;

   mcu_cycle_timer u_timer (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_cycle_length_option(i_cycle_length_option),
      .o_cycle_end(cycle_end)
   );

   // ==========================================================
   // Field split
   wire lit_grp = instr_r[`F_TOP];
   wire bit_grp = ~instr_r[`F_TOP] & instr_r[11];
   wire [5:0] op6 = instr_r[11:6];
   wire [5:0] low6 = instr_r[5:0];
   wire [1:0] bit_op = instr_r[10:9];
   wire [2:0] bit_sel = instr_r[8:6];
   wire [7:0] literal = instr_r[7:0];
   wire dest_reg = instr_r[`F_DEST];
   wire ctl_grp = ~lit_grp & ~bit_grp & (op6 == 6'h00);

   // ==========================================================
   // Control opcodes
   wire is_daa = ctl_grp & (low6 == `OP_DAA);
   wire is_ctrlw = ctl_grp & (low6 == `OP_CTRLW);
   wire is_ctrlr = ctl_grp & (low6 == `OP_CTRLR);
   wire is_sleep = ctl_grp & (low6 == `OP_SLEEP);
   wire is_watchdog_clear_op = ctl_grp & (low6 == `OP_WATCHDOG_CLEAR_OP);
   wire is_eni = ctl_grp & (low6 == `OP_ENI);
   wire is_irq_disable_op = ctl_grp & (low6 == `OP_IRQ_DISABLE_OP);
   wire is_ret = ctl_grp & (low6 == `OP_RET);
   wire is_irq_return_op = ctl_grp & (low6 == `OP_IRQ_RETURN_OP);
   wire is_iow = ctl_grp & (low6[5:4] == 2'b00) & io_sel_ok(low6[3:0]);
   wire is_ior = ctl_grp & (low6[5:4] == 2'b01) & io_sel_ok(low6[3:0]);
   wire is_return_literal_op = lit_grp & (instr_r[11:8] == `LIT_RETURN_LITERAL_OP);
   wire is_table_read_op = lit_grp & (instr_r[11:6] == `LIT_TABLE_READ_OP);

   // ==========================================================
   // Register-operand decode
   reg [4:0] alu_op;
   reg wr_reg;
   reg wr_acc;
   reg upd_z;
   reg upd_cdc;
   reg upd_c;
   reg skip_z;
   reg skip_bit;

   always @* begin
      alu_op = `ALU_PASS;
      wr_reg = 1'b0;
      wr_acc = 1'b0;
      upd_z = 1'b0;
      upd_cdc = 1'b0;
      upd_c = 1'b0;
      skip_z = 1'b0;
      skip_bit = 1'b0;
      if (is_daa) begin
         alu_op = `ALU_DAA;
         wr_acc = 1'b1;
         upd_c = 1'b1;
      end else if (bit_grp) begin
         // Bit field ops on any register, I/O included
         case (bit_op)
            2'b00: begin
               alu_op = `ALU_BCLR;
               wr_reg = 1'b1;
            end
            2'b01: begin
               alu_op = `ALU_BSET;
               wr_reg = 1'b1;
            end
            2'b10: skip_bit = ~i_reg_rdata[bit_sel];
            2'b11: skip_bit = i_reg_rdata[bit_sel];
            default: skip_bit = 1'b0;
         endcase
      end else if (~lit_grp) begin
         // Same opcodes serve general and I/O registers
         case (op6[5:1])
            5'h00: begin
               if (op6[0]) begin
                  alu_op = `ALU_PASSA;
                  wr_reg = 1'b1;
               end
            end
            5'h01: begin
               if (op6[0] || (low6 == 6'h00)) begin
                  alu_op = `ALU_ZERO;
                  wr_reg = op6[0];
                  wr_acc = ~op6[0];
                  upd_z = 1'b1;
               end
            end
            5'h02: begin
               alu_op = `ALU_SUB;
               upd_cdc = 1'b1;
               upd_z = 1'b1;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            5'h03: begin
               alu_op = `ALU_DEC;
               upd_z = 1'b1;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            5'h04: begin
               alu_op = `ALU_OR;
               upd_z = 1'b1;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            5'h05: begin
               alu_op = `ALU_AND;
               upd_z = 1'b1;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            5'h06: begin
               alu_op = `ALU_XOR;
               upd_z = 1'b1;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            5'h07: begin
               alu_op = `ALU_ADD;
               upd_z = 1'b1;
               upd_cdc = 1'b1;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            5'h08: begin
               alu_op = `ALU_PASS;
               upd_z = 1'b1;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            5'h09: begin
               alu_op = `ALU_COM;
               upd_z = 1'b1;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            5'h0a: begin
               alu_op = `ALU_INC;
               upd_z = 1'b1;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            5'h0b: begin
               alu_op = `ALU_DEC;
               skip_z = 1'b1;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            5'h0c: begin
               alu_op = `ALU_RRC;
               upd_c = 1'b1;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            5'h0d: begin
               alu_op = `ALU_RLC;
               upd_c = 1'b1;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            5'h0e: begin
               alu_op = `ALU_SWAP;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            5'h0f: begin
               alu_op = `ALU_INC;
               skip_z = 1'b1;
               wr_reg = dest_reg;
               wr_acc = ~dest_reg;
            end
            default: alu_op = `ALU_PASS;
         endcase
      end
   end

   mcu_alu u_alu (
      .i_op(alu_op),
      .i_a(o_acc_r),
      .i_r(i_reg_rdata),
      .i_bit(bit_sel),
      .i_c(o_carry_flag_r),
      .i_dc(o_digit_carry_flag_r),
      .o_y(alu_y),
      .o_c(alu_c),
      .o_dc(alu_dc)
   );

   // ==========================================================
   // Cycle count
   wire skip_hit = skip_bit | (skip_z & (alu_y == 8'h00));
   wire pc_write = wr_reg & (o_reg_addr_r == `PC_REG_ADDR);
   wire two_cyc = pc_write | skip_hit | is_ret | is_irq_return_op | is_return_literal_op | is_table_read_op;
   wire exec_end = (st_r == S_EXEC) & cycle_end;
   wire wait_end = (st_r == S_WAIT) & cycle_end;

   assign o_fetch_ready = cycle_end & ((st_r == S_IDLE) | (st_r == S_WAIT) |
      ((st_r == S_EXEC) & ~two_cyc));

   always @* begin
      case (st_r)
         S_IDLE: st_nxt = (o_fetch_ready & i_instr_valid) ? S_EXEC : S_IDLE;
         S_EXEC: begin
            if (cycle_end && two_cyc) begin
               st_nxt = S_WAIT;
            end else if (o_fetch_ready && i_instr_valid) begin
               st_nxt = S_EXEC;
            end else if (cycle_end) begin
               st_nxt = S_IDLE;
            end else begin
               st_nxt = S_EXEC;
            end
         end
         S_WAIT: begin
            if (cycle_end) begin
               st_nxt = i_instr_valid ? S_EXEC : S_IDLE;
            end else begin
               st_nxt = S_WAIT;
            end
         end
         default: st_nxt = S_IDLE;
      endcase
   end

   // ==========================================================
   // Sequencer and instruction latch
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= S_IDLE;
         instr_r <= 13'h0000;
         o_reg_addr_r <= 6'h00;
         table_read_op_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (o_fetch_ready && i_instr_valid) begin
            instr_r <= i_instr;
         end
         // Selector follows the latched word, held while a write pulse is due
         if (!(exec_end || wait_end)) begin
            o_reg_addr_r <= instr_r[5:0];
         end
         if (exec_end) begin
            table_read_op_r <= is_table_read_op;
         end else if (wait_end) begin
            table_read_op_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Execution effects
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_reg_we_r <= 1'b0;
         o_reg_wdata_r <= 8'h00;
         o_ctrl_we_r <= 1'b0;
         o_ctrl_wdata_r <= 8'h00;
         o_ioc_addr_r <= 4'h0;
         o_ioc_we_r <= 1'b0;
         o_ioc_wdata_r <= 8'h00;
         o_table_req_r <= 1'b0;
         o_stack_pop_r <= 1'b0;
         o_skip_r <= 1'b0;
         o_flush_r <= 1'b0;
         o_done_r <= 1'b0;
         o_wdt_clear_r <= 1'b0;
         o_sleep_r <= 1'b0;
         o_timeout_flag_r <= `RST_TIMEOUT;
         o_powerdown_flag_r <= `RST_POWERDOWN;
         o_irq_enable_r <= `RST_IRQ_EN;
         o_acc_r <= `RST_ACC;
         o_zero_flag_r <= 1'b0;
         o_carry_flag_r <= 1'b0;
         o_digit_carry_flag_r <= 1'b0;
      end else begin
         o_reg_we_r <= 1'b0;
         o_ctrl_we_r <= 1'b0;
         o_ioc_we_r <= 1'b0;
         o_stack_pop_r <= 1'b0;
         o_skip_r <= 1'b0;
         o_flush_r <= 1'b0;
         o_done_r <= 1'b0;
         o_wdt_clear_r <= 1'b0;
         o_sleep_r <= 1'b0;
         if (!exec_end) begin
            o_ioc_addr_r <= instr_r[3:0];
         end
         if (exec_end) begin
            o_done_r <= ~two_cyc;
            o_table_req_r <= is_table_read_op;
            if (wr_reg) begin
               o_reg_we_r <= 1'b1;
               o_reg_wdata_r <= alu_y;
            end
            if (wr_acc) begin
               o_acc_r <= alu_y;
            end
            if (upd_z) begin
               o_zero_flag_r <= (alu_y == 8'h00);
            end
            if (upd_cdc) begin
               o_carry_flag_r <= alu_c;
               o_digit_carry_flag_r <= alu_dc;
            end
            if (upd_c) begin
               o_carry_flag_r <= alu_c;
            end
            o_skip_r <= skip_hit;
            if (is_ctrlw) begin
               o_ctrl_we_r <= 1'b1;
               o_ctrl_wdata_r <= o_acc_r;
            end
            if (is_ctrlr) begin
               o_acc_r <= i_ctrl_rdata;
            end
            if (is_iow) begin
               o_ioc_we_r <= 1'b1;
               o_ioc_wdata_r <= o_acc_r;
            end
            if (is_ior) begin
               o_acc_r <= i_ioc_rdata;
            end
            if (is_sleep) begin
               o_wdt_clear_r <= 1'b1;
               o_sleep_r <= 1'b1;
               o_timeout_flag_r <= 1'b1;
               o_powerdown_flag_r <= 1'b0;
            end
            if (is_watchdog_clear_op) begin
               o_wdt_clear_r <= 1'b1;
               o_timeout_flag_r <= 1'b1;
               o_powerdown_flag_r <= 1'b1;
            end
            if (is_eni || is_irq_return_op) begin
               o_irq_enable_r <= 1'b1;
            end
            if (is_irq_disable_op) begin
               o_irq_enable_r <= 1'b0;
            end
            if (is_ret || is_irq_return_op || is_return_literal_op) begin
               o_stack_pop_r <= 1'b1;
            end
            if (is_return_literal_op) begin
               o_acc_r <= literal;
            end
         end
         if (wait_end) begin
            o_flush_r <= 1'b1;
            o_done_r <= 1'b1;
            o_table_req_r <= 1'b0;
            if (table_read_op_r) begin
               o_reg_we_r <= 1'b1;
               o_reg_wdata_r <= i_table_data;
            end
         end
      end
   end

endmodule
`default_nettype wire

/* File: tb/mcu_decoder_chk.sv */
// Assertion checker for the instruction decoder ports
`timescale 1ns/1ps
`default_nettype none
module mcu_decoder_chk (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic [1:0] i_cycle_length_option,
   input wire logic i_instr_valid,
   input wire logic [12:0] i_instr,
   input wire logic o_fetch_ready,
   input wire logic o_reg_we_r,
   input wire logic o_stack_pop_r,
   input wire logic o_done_r,
   input wire logic o_wdt_clear_r,
   input wire logic o_sleep_r,
   input wire logic o_powerdown_flag_r,
   input wire logic o_timeout_flag_r,
   input wire logic o_irq_enable_r,
   input wire logic [7:0] o_acc_r,
   input wire logic o_zero_flag_r,
   input wire logic o_carry_flag_r
);
   // ==========
   // Properties
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   wire tk2 = o_fetch_ready && i_instr_valid && i_cycle_length_option == 2'b01;
   sequence s_go(logic [12:0] w);
      tk2 && i_instr == w;
   endsequence
   sequence s_two;
      ##3 o_stack_pop_r ##2 o_done_r;
   endsequence
   property p_pace2;
      o_fetch_ready && i_cycle_length_option == 2'b01 |=> !o_fetch_ready;
   endproperty
   a_pace2: assert property (p_pace2) else $error("fetch too soon");
   property p_pace4;
      o_fetch_ready && i_cycle_length_option == 2'b00 |=> !o_fetch_ready [*3];
   endproperty
   a_pace4: assert property (p_pace4) else $error("fetch too soon");
   property p_store;
      tk2 && i_instr[12:6] == 7'h01 |-> ##3 o_reg_we_r && $stable(o_zero_flag_r)
         && $stable(o_carry_flag_r);
   endproperty
   a_store: assert property (p_store) else $error("store bad");
   property p_clear_acc_op;
      s_go(13'h0080) |-> ##3 o_acc_r == 8'h00 && o_zero_flag_r;
   endproperty
   a_clear_acc_op: assert property (p_clear_acc_op) else $error("clear bad");
   property p_eni;
      s_go(13'h0010) |-> ##3 o_irq_enable_r;
   endproperty
   a_eni: assert property (p_eni) else $error("enable bad");
   property p_irq_disable_op;
      s_go(13'h0011) |-> ##3 !o_irq_enable_r;
   endproperty
   a_irq_disable_op: assert property (p_irq_disable_op) else $error("disable bad");
   property p_ret;
      s_go(13'h0012) |-> s_two;
   endproperty
   a_ret: assert property (p_ret) else $error("return bad");
   property p_irq_return_op;
      s_go(13'h0013) |-> s_two ##0 o_irq_enable_r;
   endproperty
   a_irq_return_op: assert property (p_irq_return_op) else $error("irq return bad");
   property p_sleep;
      s_go(13'h0003) |-> ##3 o_sleep_r && o_wdt_clear_r && !o_powerdown_flag_r
         && o_timeout_flag_r;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep bad");
   property p_watchdog_clear_op;
      s_go(13'h0004) |-> ##3 o_wdt_clear_r && !o_sleep_r && o_powerdown_flag_r;
   endproperty
   a_watchdog_clear_op: assert property (p_watchdog_clear_op) else $error("wdt clear bad");
endmodule
bind mcu_instruction_decoder mcu_decoder_chk i_chk (.*);
`default_nettype wire

/* File: tb/mcu_far_side.sv */
// Register file, control registers and a fixed table data source beside the decoder
`timescale 1ns/1ps
`default_nettype none
module mcu_far_side (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic [5:0] i_addr,
   input wire logic i_we,
   input wire logic [7:0] i_wdata,
   input wire logic i_ctrl_we,
   input wire logic [7:0] i_ctrl_wdata,
   input wire logic [3:0] i_ioc_addr,
   input wire logic i_ioc_we,
   input wire logic [7:0] i_ioc_wdata,
   input wire logic i_table_req,
   output logic [7:0] o_rdata,
   output logic [7:0] o_ctrl_rdata,
   output logic [7:0] o_ioc_rdata,
   output logic [7:0] o_table_data
);
   // ==========
   // Storage
   logic [7:0] mem [0:63];
   logic [7:0] ioc [0:15];
   logic [7:0] ctrl_r;
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int i = 0; i < 64; i++) mem[i] <= 8'(i);
         for (int i = 0; i < 16; i++) ioc[i] <= 8'h30 + 8'(i);
         ctrl_r <= 8'h00;
      end else begin
         if (i_we) mem[i_addr] <= i_wdata;
         if (i_ioc_we) ioc[i_ioc_addr] <= i_ioc_wdata;
         if (i_ctrl_we) ctrl_r <= i_ctrl_wdata;
      end
   end
   assign o_rdata = mem[i_addr];
   assign o_ctrl_rdata = ctrl_r;
   assign o_ioc_rdata = ioc[i_ioc_addr];
   // Table data only valid in the second cycle
   assign o_table_data = i_table_req ? 8'h5a : 8'ha5;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking testbench of the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic i_clk_sys, i_rst_b, i_instr_valid;
   logic [1:0] i_cycle_length_option;
   logic [12:0] i_instr;
   wire [7:0] i_reg_rdata, i_ctrl_rdata, i_ioc_rdata, i_table_data, o_reg_wdata_r;
   wire [7:0] o_ctrl_wdata_r, o_ioc_wdata_r, o_acc_r;
   wire [5:0] o_reg_addr_r;
   wire [3:0] o_ioc_addr_r;
   wire o_fetch_ready, o_reg_we_r, o_ctrl_we_r, o_ioc_we_r, o_table_req_r, o_stack_pop_r;
   wire o_skip_r, o_flush_r, o_done_r, o_wdt_clear_r, o_sleep_r, o_timeout_flag_r;
   wire o_powerdown_flag_r, o_irq_enable_r, o_zero_flag_r, o_carry_flag_r, o_digit_carry_flag_r;
   integer failures = 0;
   integer n_compared = 0;
   mcu_instruction_decoder i_mcu_instruction_decoder (.*);
   mcu_far_side i_mcu_far_side (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
      .i_addr(o_reg_addr_r), .i_we(o_reg_we_r), .i_wdata(o_reg_wdata_r),
      .i_ctrl_we(o_ctrl_we_r), .i_ctrl_wdata(o_ctrl_wdata_r), .i_ioc_addr(o_ioc_addr_r),
      .i_ioc_we(o_ioc_we_r), .i_ioc_wdata(o_ioc_wdata_r), .i_table_req(o_table_req_r),
      .o_rdata(i_reg_rdata), .o_ctrl_rdata(i_ctrl_rdata), .o_ioc_rdata(i_ioc_rdata),
      .o_table_data(i_table_data));
   // ==========
   // Tasks
   task summarize;
      begin
         $display("Compared %0d, failures %0d", n_compared, failures);
         if (failures == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
         end else begin
            $display("Run complete: FAIL");
         end
         $finish;
      end
   endtask
   task cmp_val(input string nm, input logic [7:0] e, input logic [7:0] g);
      begin
         n_compared++;
         if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task exec(input logic [12:0] w, input logic [7:0] ea, input logic [2:0] ef, input int ec);
      int n;
      begin
         @(posedge i_clk_sys);
         i_instr <= w;
         i_instr_valid <= 1'b1;
         n = 0;
         @(negedge i_clk_sys);
         while (o_fetch_ready !== 1'b1 && n < 40) begin
            @(negedge i_clk_sys);
            n++;
         end
         @(posedge i_clk_sys);
         i_instr_valid <= 1'b0;
         n = 0;
         @(negedge i_clk_sys);
         while (o_done_r !== 1'b1 && n < 40) begin
            @(negedge i_clk_sys);
            n++;
         end
         cmp_val("acc", ea, o_acc_r);
         cmp_val("flags", {5'h0, ef}, {5'h0, o_zero_flag_r, o_carry_flag_r,
            o_digit_carry_flag_r});
         cmp_val("cycles", 8'(ec), 8'(n));
      end
   endtask
   // ==========
   // Sequence
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      #50000;
      failures++;
      summarize;
   end
   initial begin
      i_rst_b = 1'b0;
      i_instr_valid = 1'b0;
      i_instr = 13'h0000;
      i_cycle_length_option = 2'b01;
      repeat (5) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      exec(13'h0080, 8'h00, 3'b100, 2);
      exec(13'h042f, 8'h2f, 3'b000, 2);
      exec(13'h03e8, 8'h2f, 3'b001, 2);
      exec(13'h0105, 8'hd6, 3'b000, 2);
      exec(13'h03bf, 8'h15, 3'b011, 2);
      exec(13'h0581, 8'h00, 3'b011, 4);
      exec(13'h0605, 8'h82, 3'b011, 2);
      exec(13'h0303, 8'h81, 3'b011, 2);
      exec(13'h0280, 8'h00, 3'b111, 2);
      exec(13'h0047, 8'h00, 3'b111, 2);
      exec(13'h0181, 8'h00, 3'b111, 2);
      cmp_val("r28", 8'h57, i_mcu_far_side.mem[40]);
      cmp_val("r07", 8'h00, i_mcu_far_side.mem[7]);
      exec(13'h053f, 8'h40, 3'b011, 2);
      exec(13'h04bf, 8'hc0, 3'b011, 2);
      $display("Test arithmetic done");
      exec(13'h0006, 8'hc0, 3'b011, 2);
      exec(13'h0002, 8'hc0, 3'b011, 2);
      exec(13'h0080, 8'h00, 3'b111, 2);
      exec(13'h0016, 8'hc0, 3'b111, 2);
      exec(13'h0080, 8'h00, 3'b111, 2);
      exec(13'h0014, 8'hc0, 3'b111, 2);
      exec(13'h0018, 8'hc0, 3'b111, 2);
      exec(13'h1ec9, 8'hc0, 3'b111, 4);
      exec(13'h0010, 8'hc0, 3'b111, 2);
      cmp_val("irq", 8'h01, {7'h0, o_irq_enable_r});
      exec(13'h0011, 8'hc0, 3'b111, 2);
      cmp_val("irq", 8'h00, {7'h0, o_irq_enable_r});
      exec(13'h0013, 8'hc0, 3'b111, 4);
      cmp_val("irq", 8'h01, {7'h0, o_irq_enable_r});
      cmp_val("r09", 8'h5a, i_mcu_far_side.mem[9]);
      exec(13'h0012, 8'hc0, 3'b111, 4);
      exec(13'h0042, 8'hc0, 3'b111, 4);
      exec(13'h0003, 8'hc0, 3'b111, 2);
      cmp_val("pd", 8'h00, {7'h0, o_powerdown_flag_r});
      exec(13'h0004, 8'hc0, 3'b111, 2);
      cmp_val("pd", 8'h01, {7'h0, o_powerdown_flag_r});
      exec(13'h0000, 8'hc0, 3'b111, 2);
      $display("Test control done");
      @(posedge i_clk_sys);
      i_rst_b <= 1'b0;
      i_cycle_length_option <= 2'b00;
      repeat (5) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      exec(13'h0000, 8'h00, 3'b000, 4);
      exec(13'h0012, 8'h00, 3'b000, 8);
      exec(13'h0080, 8'h00, 3'b100, 4);
      $display("Test slow cycle done");
      summarize;
   end
endmodule
`default_nettype wire
